/* core/sps_consts.svh */
// Purpose: Named offsets, bit positions, reset values and rate divisors.
// Assumes: Included by the package and by the serial port core.
// Notes:   Definitions only.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

`define SPS_ADDR_W          16
`define SPS_OFF_CONTROL     16'h2540
`define SPS_OFF_STATUS      16'h2541
`define SPS_OFF_DATA        16'h2542
`define SPS_OFF_RATE_COUNT  16'h2543

`define SPS_CTL_IRQ_GATE    7
`define SPS_CTL_PORT_ON     6
`define SPS_CTL_LEADER      4
`define SPS_CTL_CPOL        3
`define SPS_CTL_CPHA        2
`define SPS_STA_DONE        7
`define SPS_STA_CLASH       6
`define SPS_STA_TXFULL      3
`define SPS_STA_TXEMPTY     2
`define SPS_STA_RXFULL      1
`define SPS_STA_RXEMPTY     0

`define SPS_RST_LEADER      1'b1
`define SPS_RST_RATE_LOW    2'h0
`define SPS_RST_RATE_HIGH   2'h2
`define SPS_RST_COUNT       2'h0
`define SPS_ZERO_BYTE       8'h00

`define SPS_LAST_EDGE       4'hf
`define SPS_HALF_8          12'h004
`define SPS_HALF_16         12'h008
`define SPS_HALF_32         12'h010
`define SPS_HALF_64         12'h020
`define SPS_HALF_128        12'h040
`define SPS_HALF_256        12'h080
`define SPS_HALF_512        12'h100
`define SPS_HALF_1024       12'h200
`define SPS_HALF_2048       12'h400
`define SPS_HALF_4096       12'h800

`endif

/* core/sps_pkg.sv */
// Purpose: Types shared by the serial port core and its bench.
// Assumes: sps_consts.svh supplies the widths.
// Notes:   Holds types only.
`include "sps_consts.svh"

package sps_pkg;

    typedef struct packed {
        logic [`SPS_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } sps_bus_req_t;

    typedef enum logic [1:0] {
        SPS_IDLE   = 2'b00,
        SPS_LEAD   = 2'b01,
        SPS_FOLLOW = 2'b10,
        SPS_SKIP   = 2'b11
    } sps_state_t;

endpackage : sps_pkg

/* core/sps_core.sv */
// Purpose: Byte-wide serial peripheral port, leader or follower, with queues.
// Assumes: One 50 MHz clock; pins are synchronised here.
// Notes:   Follower timing relies on SCK well below a quarter of clk_i.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "sps_consts.svh"

// Function
// - Shift out and in simultaneously.
// - Leader: data write starts a transfer.
// - Leader: data read returns received byte.
// - Follower: empty queue means no exchange.
// - Follower: received byte readable from data.
// - Control bit 7 gates interrupt.
// - Control bit 6 enables port; bit 5 zero.
// - Control bit 4 selects leader, resets 1.
// - Control bit 3 sets SCK idle level.
// - Equal polarity/phase: change falling, sample rising.
// - Differing: change rising, sample falling.
// - Leader SCK divided by 4-bit rate code.
// - Rate code halves reset to 2, 0.
// - Status bit 7 set per byte, sticky.
// - Status bit 6 flags write when full.
// - Status bits 3, 2 show tx full/empty.
// - Status bit 1 shows rx full.
// - Status bit 0 shows rx empty.
// - Count field stored; flag per byte.
module sps_core
    import sps_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
)(
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    input  wire sps_bus_req_t bus_req_i,
    output logic [7:0]        rd_data_o,
    input  wire logic         sck_i,
    output logic              sck_o,
    output logic              sck_oe_o,
    input  wire logic         mosi_i,
    output logic              mosi_o,
    output logic              mosi_oe_o,
    input  wire logic         miso_i,
    output logic              miso_o,
    output logic              miso_oe_o,
    input  wire logic         sel_n_i,
    output logic              irq_o
);

    localparam int PW = $clog2(FIFO_DEPTH);

    generate
        if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH)
        begin : g_bad_depth
            $error("FIFO_DEPTH must be a power of two, at least 2.");
        end
    endgenerate

    function automatic logic [11:0] half_period(input logic [3:0] code);
        logic [11:0] h;
        h = `SPS_HALF_8;
        unique case (code)
            4'h3: h = `SPS_HALF_32;
            4'h4: h = `SPS_HALF_64;
            4'h5: h = `SPS_HALF_16;
            4'h6: h = `SPS_HALF_128;
            4'h7: h = `SPS_HALF_256;
            4'h8: h = `SPS_HALF_512;
            4'h9: h = `SPS_HALF_1024;
            4'ha: h = `SPS_HALF_2048;
            4'hb: h = `SPS_HALF_4096;
            default: h = `SPS_HALF_8;
        endcase
        return h;
    endfunction : half_period

    logic             rst_m1_n;
    logic             rst_n;
    logic [2:0]       pin_m1;
    logic [2:0]       pin_s;
    logic             sck_d;
    logic             irq_gate;
    logic             port_on;
    logic             leader_select;
    logic             cpol;
    logic             cpha;
    logic [1:0]       rate_code_low;
    logic [1:0]       rate_code_high;
    logic [1:0]       bytes_per_irq;
    logic             transfer_done_flag;
    logic             write_clash_flag;
    logic [7:0]       tx_mem [FIFO_DEPTH];
    logic [7:0]       rx_mem [FIFO_DEPTH];
    logic [PW-1:0]    tx_wp;
    logic [PW-1:0]    tx_rp;
    logic [PW:0]      tx_cnt;
    logic [PW-1:0]    rx_wp;
    logic [PW-1:0]    rx_rp;
    logic [PW:0]      rx_cnt;
    sps_state_t       state;
    logic [11:0]      hcnt;
    logic [3:0]       ecnt;
    logic [2:0]       bcnt;
    logic             sck_reg;
    logic [7:0]       sh;
    logic             dout;
    logic             din_bit;

    logic             wr_ctl;
    logic             wr_sta;
    logic             wr_dat;
    logic             wr_rc;
    logic             rd_dat;
    logic             tx_full;
    logic             tx_empty;
    logic             rx_full;
    logic             rx_empty;
    logic             tx_push;
    logic             tx_pop;
    logic             rx_pop;
    logic             byte_done;
    logic             lead_ev;
    logic             trail_ev;
    logic             din;
    logic             selected;
    logic             sck_edge;
    logic [11:0]      half;
    logic [7:0]       next_sh;

    // Reset release through two flops.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_m1_n <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_m1_n <= 1'b1;
            rst_n    <= rst_m1_n;
        end
    end

    // Pin synchronisers: sck, mosi, miso; select idles high.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_m1 <= 3'h0;
            pin_s  <= 3'h0;
            sck_d  <= 1'b0;
        end
        else if (ce_i)
        begin
            pin_m1 <= {sck_i, mosi_i, miso_i};
            pin_s  <= pin_m1;
            sck_d  <= pin_s[2];
        end
    end

    logic sel_m1_n;
    logic sel_s_n;
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_m1_n <= 1'b1;
            sel_s_n  <= 1'b1;
        end
        else if (ce_i)
        begin
            sel_m1_n <= sel_n_i;
            sel_s_n  <= sel_m1_n;
        end
    end

    assign wr_ctl = bus_req_i.wr && bus_req_i.addr == `SPS_OFF_CONTROL;
    assign wr_sta = bus_req_i.wr && bus_req_i.addr == `SPS_OFF_STATUS;
    assign wr_dat = bus_req_i.wr && bus_req_i.addr == `SPS_OFF_DATA;
    assign wr_rc  = bus_req_i.wr && bus_req_i.addr == `SPS_OFF_RATE_COUNT;
    assign rd_dat = bus_req_i.rd && bus_req_i.addr == `SPS_OFF_DATA;

    assign tx_full  = tx_cnt == (PW+1)'(FIFO_DEPTH);
    assign tx_empty = tx_cnt == '0;
    assign rx_full  = rx_cnt == (PW+1)'(FIFO_DEPTH);
    assign rx_empty = rx_cnt == '0;
    assign tx_push  = wr_dat && !tx_full;
    assign rx_pop   = rd_dat && !rx_empty;
    assign selected = !sel_s_n;
    assign din      = leader_select ? pin_s[0] : pin_s[1];
    assign half     = half_period({rate_code_high, rate_code_low});

    // Control register.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_gate      <= 1'b0;
            port_on       <= 1'b0;
            leader_select <= `SPS_RST_LEADER;
            cpol          <= 1'b0;
            cpha          <= 1'b0;
            rate_code_low <= `SPS_RST_RATE_LOW;
        end
        else if (ce_i && wr_ctl)
        begin
            irq_gate      <= bus_req_i.wdata[`SPS_CTL_IRQ_GATE];
            port_on       <= bus_req_i.wdata[`SPS_CTL_PORT_ON];
            leader_select <= bus_req_i.wdata[`SPS_CTL_LEADER];
            cpol          <= bus_req_i.wdata[`SPS_CTL_CPOL];
            cpha          <= bus_req_i.wdata[`SPS_CTL_CPHA];
            rate_code_low <= bus_req_i.wdata[1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_code_high <= `SPS_RST_RATE_HIGH;
            bytes_per_irq  <= `SPS_RST_COUNT;
        end
        else if (ce_i && wr_rc)
        begin
            rate_code_high <= bus_req_i.wdata[1:0];
            bytes_per_irq  <= bus_req_i.wdata[7:6];
        end
    end

    // Sticky flags; a hardware set beats a software clear.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transfer_done_flag <= 1'b0;
            write_clash_flag   <= 1'b0;
        end
        else if (ce_i)
        begin
            if (byte_done)
                transfer_done_flag <= 1'b1;
            else if (wr_sta)
                transfer_done_flag <= bus_req_i.wdata[`SPS_STA_DONE];
            if (wr_dat && tx_full)
                write_clash_flag <= 1'b1;
            else if (wr_sta)
                write_clash_flag <= bus_req_i.wdata[`SPS_STA_CLASH];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            irq_o <= 1'b0;
        else if (ce_i)
            irq_o <= irq_gate && transfer_done_flag;
    end

    // Transmit queue; a write while full is dropped.
    always_ff @(posedge clk_i)
    begin
        if (ce_i && tx_push)
            tx_mem[tx_wp] <= bus_req_i.wdata;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end
        else if (ce_i)
        begin
            if (tx_push)
                tx_wp <= tx_wp + 1'b1;
            if (tx_pop)
                tx_rp <= tx_rp + 1'b1;
            tx_cnt <= tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
        end
    end

    // Receive queue; a byte arriving while full is lost.
    always_ff @(posedge clk_i)
    begin
        if (ce_i && byte_done && !rx_full)
            rx_mem[rx_wp] <= next_sh;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= '0;
        end
        else if (ce_i)
        begin
            if (byte_done && !rx_full)
                rx_wp <= rx_wp + 1'b1;
            if (rx_pop)
                rx_rp <= rx_rp + 1'b1;
            rx_cnt <= rx_cnt + (PW+1)'(byte_done && !rx_full)
                      - (PW+1)'(rx_pop);
        end
    end

    // Read data stand one cycle after the strobe only.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_o <= `SPS_ZERO_BYTE;
        else if (ce_i)
        begin
            rd_data_o <= `SPS_ZERO_BYTE;
            if (bus_req_i.rd)
            begin
                unique case (bus_req_i.addr)
                    `SPS_OFF_CONTROL:
                        rd_data_o <= {irq_gate, port_on, 1'b0,
                                      leader_select, cpol, cpha,
                                      rate_code_low};
                    `SPS_OFF_STATUS:
                        rd_data_o <= {transfer_done_flag, write_clash_flag,
                                      2'b00, tx_full, tx_empty,
                                      rx_full, rx_empty};
                    `SPS_OFF_DATA:
                        rd_data_o <= rx_empty ? `SPS_ZERO_BYTE
                                              : rx_mem[rx_rp];
                    `SPS_OFF_RATE_COUNT:
                        rd_data_o <= {bytes_per_irq, 4'h0,
                                      rate_code_high};
                    default:
                        rd_data_o <= `SPS_ZERO_BYTE;
                endcase
            end
        end
    end

    // Leading edge samples when phase is 0.
    // Trailing edge samples when phase is 1.
    assign sck_edge = pin_s[2] != sck_d;
    always_comb
    begin
        lead_ev  = 1'b0;
        trail_ev = 1'b0;
        if (state == SPS_LEAD && hcnt == half - 12'h001)
        begin
            lead_ev  = !ecnt[0];
            trail_ev = ecnt[0];
        end
        else if (state == SPS_FOLLOW && sck_edge)
        begin
            lead_ev  = pin_s[2] != cpol;
            trail_ev = pin_s[2] == cpol;
        end
    end

    // One shift gathers the incoming bit.
    assign next_sh   = cpha ? {sh[6:0], din} : {sh[6:0], din_bit};
    assign byte_done = trail_ev && bcnt == 3'h7;
    assign tx_pop    = state == SPS_IDLE && port_on && !tx_empty
                       && (leader_select || selected);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            state <= SPS_IDLE;
        else if (ce_i)
        begin
            if (!port_on)
                state <= SPS_IDLE;
            else
            begin
                unique case (state)
                    SPS_IDLE:
                        if (tx_pop)
                            state <= leader_select ? SPS_LEAD : SPS_FOLLOW;
                        else if (!leader_select && selected && sck_edge)
                            state <= SPS_SKIP;
                    SPS_LEAD:
                        if (byte_done)
                            state <= SPS_IDLE;
                    SPS_FOLLOW:
                        if (byte_done || !selected)
                            state <= SPS_IDLE;
                    SPS_SKIP:
                        if (!selected)
                            state <= SPS_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hcnt    <= '0;
            ecnt    <= '0;
            sck_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (state != SPS_LEAD)
            begin
                hcnt    <= '0;
                ecnt    <= '0;
                sck_reg <= cpol;
            end
            else if (hcnt == half - 12'h001)
            begin
                hcnt    <= '0;
                ecnt    <= ecnt + 4'h1;
                sck_reg <= !sck_reg;
            end
            else
                hcnt <= hcnt + 12'h001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh      <= `SPS_ZERO_BYTE;
            dout    <= 1'b0;
            din_bit <= 1'b0;
            bcnt    <= '0;
        end
        else if (ce_i)
        begin
            if (tx_pop)
            begin
                sh   <= tx_mem[tx_rp];
                dout <= tx_mem[tx_rp][7];
                bcnt <= '0;
            end
            else if (lead_ev)
            begin
                if (cpha)
                    dout <= sh[7];
                else
                    din_bit <= din;
            end
            else if (trail_ev)
            begin
                sh   <= next_sh;
                bcnt <= bcnt + 3'h1;
                if (!cpha)
                    dout <= sh[6];
            end
        end
    end

    // Pin drive: leader drives SCK and MOSI; a selected follower in an exchange drives MISO.
    assign sck_o     = leader_select ? sck_reg : cpol;
    assign sck_oe_o  = port_on && leader_select;
    assign mosi_o    = dout;
    assign mosi_oe_o = port_on && leader_select;
    assign miso_o    = dout;
    assign miso_oe_o = port_on && !leader_select && selected
                       && state == SPS_FOLLOW;

endmodule : sps_core

/* verif/sps_core_checker.sv */
// Purpose: Port checks for the serial port core.
// Assumes: ce_i is held high by the bench.
// Notes:   Bit timing on the wire is judged by the bench.
`timescale 1ns/100ps
`include "sps_consts.svh"
module sps_core_checker
    import sps_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
)(
    input wire logic         clk_i,
    input wire logic         rstn_i,
    input wire logic         ce_i,
    input wire sps_bus_req_t bus_req_i,
    input wire logic [7:0]   rd_data_o,
    input wire logic         sck_i,
    input wire logic         sck_o,
    input wire logic         sck_oe_o,
    input wire logic         mosi_i,
    input wire logic         mosi_o,
    input wire logic         mosi_oe_o,
    input wire logic         miso_i,
    input wire logic         miso_o,
    input wire logic         miso_oe_o,
    input wire logic         sel_n_i,
    input wire logic         irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic rd_on;
    assign rd_on = bus_req_i.rd;
    property p_rd_idle;
        !rd_on |=> rd_data_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale read");
    property p_rd_bad;
        rd_on && (bus_req_i.addr < `SPS_OFF_CONTROL ||
        bus_req_i.addr > `SPS_OFF_RATE_COUNT) |=> rd_data_o == 8'h00;
    endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped data");
    property p_ctl_rsv;
        rd_on && bus_req_i.addr == `SPS_OFF_CONTROL |=> !rd_data_o[5];
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("bit 5 set");
    property p_sta;
        rd_on && bus_req_i.addr == `SPS_OFF_STATUS |=>
        rd_data_o[5:4] == 2'h0 && !(rd_data_o[3] && rd_data_o[2]) &&
        !(rd_data_o[1] && rd_data_o[0]);
    endproperty
    a_sta: assert property (p_sta) else $error("status clash");
    property p_cnt_rsv;
        rd_on && bus_req_i.addr == `SPS_OFF_RATE_COUNT |=>
        rd_data_o[5:2] == 4'h0;
    endproperty
    a_cnt_rsv: assert property (p_cnt_rsv) else $error("rate rsv");
    sequence s_gate_off;
        bus_req_i.wr && bus_req_i.addr == `SPS_OFF_CONTROL &&
        !bus_req_i.wdata[`SPS_CTL_IRQ_GATE];
    endsequence
    property p_gate;
        s_gate_off |-> ##2 !irq_o;
    endproperty
    a_gate: assert property (p_gate) else $error("irq not gated");
    sequence s_sck_edge;
        sck_oe_o && $changed(sck_o);
    endsequence
    property p_sck_hold;
        s_sck_edge |=> $stable(sck_o)[*3];
    endproperty
    a_sck_hold: assert property (p_sck_hold) else $error("sck fast");
    property p_roles;
        sck_oe_o == mosi_oe_o && !(miso_oe_o && sck_oe_o);
    endproperty
    a_roles: assert property (p_roles) else $error("pin roles");
    property p_desel;
        sel_n_i[*5] |-> !miso_oe_o;
    endproperty
    a_desel: assert property (p_desel) else $error("miso driven");
endmodule : sps_core_checker

bind sps_core sps_core_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .bus_req_i(bus_req_i),
    .rd_data_o(rd_data_o), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .sel_n_i(sel_n_i), .irq_o(irq_o));

/* verif/sps_ext_dev.sv */
// Purpose: Far-side follower device answering the leader port.
// Assumes: en_i stands for its select and is low outside bytes.
// Notes:   It has no select pin, so en_i must hide stray edges.
`timescale 1ns/100ps
module sps_ext_dev (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       en_i,
    input  wire logic [7:0] reply_i,
    output logic            miso_o,
    output logic [7:0]      got_o,
    output int              bits_o
);
    logic [2:0] chg;
    logic       bit_out;
    initial
    begin
        chg = 3'h0;
        got_o = 8'h00;
        bits_o = 0;
    end
    always @(sck_i or negedge en_i)
    begin
        if (!en_i)
            chg = 3'h0;
        else if (sck_i ^ cpol_i ^ cpha_i)
        begin
            got_o = {got_o[6:0], mosi_i};
            bits_o++;
        end
        else
            chg++;
    end
    assign bit_out = reply_i[3'h7 - (chg - {2'h0, cpha_i})];
    // A released line shows the inverse, not a held value.
    assign miso_o = en_i ? bit_out : ~bit_out;
endmodule : sps_ext_dev

/* verif/test_sps_core.sv */
// Purpose: Self-checking bench for the serial port core.
// Assumes: ce_i high; follower SCK far below clk_i.
// Notes:   The slowest rate codes take most of the run.
`timescale 1ns/100ps
`include "sps_consts.svh"
module test_sps_core
    import sps_pkg::*;
;
    typedef struct {
        logic [3:0] code;
        int         div;
        logic [7:0] tx;
        logic [7:0] rx;
    } sps_row_t;
    sps_row_t     rows [10] = '{
        '{4'h2, 8, 8'ha5, 8'h3c}, '{4'h5, 16, 8'h81, 8'h7e},
        '{4'h3, 32, 8'h01, 8'h80}, '{4'h4, 64, 8'hff, 8'h00},
        '{4'h6, 128, 8'h5a, 8'hc6}, '{4'h7, 256, 8'h24, 8'hdb},
        '{4'h8, 512, 8'h96, 8'h69}, '{4'h9, 1024, 8'h0f, 8'hf0},
        '{4'ha, 2048, 8'hc3, 8'h3c}, '{4'hb, 4096, 8'h70, 8'h0e}};
    logic         clk_i = 1'b0;
    logic         rstn_i = 1'b0;
    sps_bus_req_t req = '0;
    logic [7:0]   rd_data_o, got, d, c;
    logic         sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    logic         irq_o, ext_miso, en = 1'b0;
    logic         sck_drv = 1'b0, mosi_drv = 1'b0, sel_n_i = 1'b1;
    logic         cpol = 1'b0, cpha = 1'b0;
    logic [7:0]   reply = 8'h00;
    wire logic    sck_w = sck_oe_o ? sck_o : sck_drv;
    wire logic    mosi_w = mosi_oe_o ? mosi_o : mosi_drv;
    wire logic    miso_w = miso_oe_o ? miso_o : ext_miso;
    int           bits, n, hi, error_cnt = 0, cmp_count = 0;

    always #10 clk_i = ~clk_i;

    sps_core #(.FIFO_DEPTH(4)) uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .bus_req_i(req),
        .rd_data_o(rd_data_o), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_o(miso_oe_o), .sel_n_i(sel_n_i), .irq_o(irq_o));
    sps_ext_dev dev (
        .sck_i(sck_w), .mosi_i(mosi_w), .cpol_i(cpol), .cpha_i(cpha),
        .en_i(en), .reply_i(reply), .miso_o(ext_miso), .got_o(got),
        .bits_o(bits));

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_n(input int g, input int e);
        cmp_count++;
        if (g != e)
        begin
            error_cnt++;
            $display("[ERR] %0t count %0d want %0d", $time, g, e);
        end
    endtask : chk_n
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_i);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_i);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_i);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        req <= '0;
        #1 v = rd_data_o;
    endtask : rd
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask : rchk
    task automatic wait_irq(output int h);
        h = 0;
        for (int k = 0; k < 40000; k++)
        begin
            @(posedge clk_i);
            #1;
            if (irq_o === 1'b1)
                return;
            if (sck_o !== cpol)
                h++;
        end
        error_cnt++;
        print_verdict();
    endtask : wait_irq
    // Mode 0 leader played by the bench, eleven clocks low and ten clocks high per bit.
    task automatic fbyte(input logic [7:0] m, output logic [7:0] s);
        @(posedge clk_i);
        sel_n_i <= 1'b0;
        for (int b = 7; b >= 0; b--)
        begin
            mosi_drv <= m[b];
            repeat (10) @(posedge clk_i);
            #1 s[b] = miso_w;
            @(posedge clk_i);
            sck_drv <= 1'b1;
            repeat (10) @(posedge clk_i);
            sck_drv <= 1'b0;
        end
        repeat (10) @(posedge clk_i);
        sel_n_i <= 1'b1;
        mosi_drv <= ~m[0];
    endtask : fbyte

    initial
    begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rchk(`SPS_OFF_CONTROL, 8'h10);
        rchk(`SPS_OFF_STATUS, 8'h05);
        rchk(`SPS_OFF_RATE_COUNT, 8'h02);
        rchk(`SPS_OFF_DATA, 8'h00);
        wr(16'h2544, 8'hff);
        rchk(16'h2544, 8'h00);
        rchk(`SPS_OFF_CONTROL, 8'h10);
        $display("reset values done");
        foreach (rows[i])
        begin
            cpol = i[0];
            cpha = i[1];
            reply = rows[i].rx;
            c = {4'hf, cpol, cpha, rows[i].code[1:0]};
            wr(`SPS_OFF_CONTROL, c);
            rchk(`SPS_OFF_CONTROL, c & 8'hdf);
            c = {i[1:0], 4'h0, rows[i].code[3:2]};
            wr(`SPS_OFF_RATE_COUNT, c);
            rchk(`SPS_OFF_RATE_COUNT, c);
            n = bits;
            en = 1'b1;
            wr(`SPS_OFF_DATA, rows[i].tx);
            wait_irq(hi);
            en = 1'b0;
            chk_n(hi, 4 * rows[i].div);
            chk_n(bits - n, 8);
            chk(got, rows[i].tx);
            chk({7'h0, sck_o}, {7'h0, cpol});
            rchk(`SPS_OFF_DATA, rows[i].rx);
            rchk(`SPS_OFF_STATUS, 8'h85);
            wr(`SPS_OFF_STATUS, 8'h00);
            rchk(`SPS_OFF_STATUS, 8'h05);
            chk({7'h0, irq_o}, 8'h00);
            $display("row %0d done", i);
        end
        @(posedge clk_i);
        sck_drv <= 1'b1;
        wr(`SPS_OFF_CONTROL, 8'h1a);
        wr(`SPS_OFF_RATE_COUNT, 8'h00);
        for (int k = 1; k < 5; k++)
            wr(`SPS_OFF_DATA, 8'(8'h11 * k));
        rchk(`SPS_OFF_STATUS, 8'h09);
        wr(`SPS_OFF_DATA, 8'hee);
        rchk(`SPS_OFF_STATUS, 8'h49);
        wr(`SPS_OFF_STATUS, 8'h00);
        n = bits;
        en = 1'b1;
        wr(`SPS_OFF_CONTROL, 8'h5a);
        d = 8'h00;
        for (int k = 0; k < 300 && !d[1]; k++)
            rd(`SPS_OFF_STATUS, d);
        if (d[1] !== 1'b1)
        begin
            error_cnt++;
            print_verdict();
        end
        en = 1'b0;
        chk_n(bits - n, 32);
        chk(got, 8'h44);
        chk({7'h0, irq_o}, 8'h00);
        rchk(`SPS_OFF_STATUS, 8'h86);
        repeat (4) rchk(`SPS_OFF_DATA, reply);
        rchk(`SPS_OFF_STATUS, 8'h85);
        $display("queue test done");
        cpol = 1'b0;
        @(posedge clk_i);
        sck_drv <= 1'b0;
        wr(`SPS_OFF_STATUS, 8'h00);
        wr(`SPS_OFF_CONTROL, 8'h40);
        fbyte(8'h5c, d);
        rchk(`SPS_OFF_STATUS, 8'h05);
        wr(`SPS_OFF_DATA, 8'hc3);
        fbyte(8'h96, d);
        chk(d, 8'hc3);
        rchk(`SPS_OFF_STATUS, 8'h84);
        rchk(`SPS_OFF_DATA, 8'h96);
        $display("follower test done");
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rchk(`SPS_OFF_CONTROL, 8'h10);
        rchk(`SPS_OFF_STATUS, 8'h05);
        $display("second reset done");
        print_verdict();
    end
endmodule : test_sps_core
